// [inc/sorb_pkg.sv]
// constants for the sensor output register bank
package sorb_pkg;
  localparam logic [7:0] SORB_ADDR_TEMP_HIGH = 8'h14;
  localparam logic [7:0] SORB_ADDR_TEMP_LOW = 8'h15;
  localparam logic [7:0] SORB_ADDR_EXT_HIGH = 8'h16;
  localparam logic [7:0] SORB_ADDR_EXT_LOW = 8'h17;
  localparam logic [7:0] SORB_ADDR_FIFO_PORT = 8'h18;
  localparam logic [7:0] SORB_ADDR_SOFT_RESTART = 8'h1F;
  localparam logic [7:0] SORB_ADDR_THR_HIGH = 8'h20;
  localparam logic [7:0] SORB_ADDR_THR_LOW = 8'h21;
  localparam logic [7:0] SORB_RESTART_CODE = 8'h52;
  localparam logic [7:0] SORB_RESET_VALUE = 8'h00;
  localparam int SORB_RESULT_W = 14;
  localparam int SORB_THR_W = 13;
  localparam int SORB_LOW_POS = 2;
  localparam int SORB_HIGH_POS = 6;
  // host wait after a software restart
  localparam int SORB_RESTART_WAIT_US = 7500;
  localparam int SORB_CLK_MHZ = 100;
  localparam int SORB_RESTART_WAIT_CYC = SORB_RESTART_WAIT_US * SORB_CLK_MHZ;
endpackage

// [design/sorb_reg_bank.sv]
// sensor output register bank with fifo read port, soft restart and activity threshold
//
// Overview of operation
// - temperature reads as 14-bit signed: eight top bits high, six low bits at [7:2].
// - external input result reads as 14-bit signed across high and low registers.
// - low result registers keep bits [1:0] zero; results read zero after reset.
// - a read at the fifo port pops one word and starts returning it.
// - a popped word goes out as two bytes, high then low, over reads.
// - continued reads of the fifo port keep popping further words.
// - multibyte reads starting at the fifo port keep the address fixed.
// - auto-increment onto the fifo port skips it without popping.
// - writing 0x52 to the restart register resets all settings and enters standby.
// - after a restart the interrupt outputs float, bus keepers hold level.
// - the restart register is write-only and reads zero.
// - activity compares magnitude of signed 14-bit samples with the 13-bit threshold.
// - threshold bits 12..6 from high register [6:0], bits 5..0 from low [7:2].
// - threshold is in raw codes, so it scales with the selected range.
`timescale 1ns/1ns
`default_nettype none
module sorb_reg_bank
  import sorb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // byte access from the serial interface engine
  input wire logic acc_start_i,
  input wire logic acc_next_i,
  input wire logic acc_write_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  // converter results, same clock
  input wire logic [SORB_RESULT_W-1:0] temp_value_i,
  input wire logic [SORB_RESULT_W-1:0] ext_input_value_i,
  input wire logic result_valid_i,
  // fifo pop side
  input wire logic [15:0] fifo_word_i,
  input wire logic fifo_empty_i,
  output logic fifo_pop_o,
  // motion sample
  input wire logic [SORB_RESULT_W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic [7:0] rdata_o,
  output logic [7:0] addr_ptr_o,
  output logic over_threshold_o,
  output logic soft_restart_o,
  output logic standby_o,
  output logic int_oe_b_o
);
  logic [7:0] ptr_q;
  logic [SORB_RESULT_W-1:0] temp_q;
  logic [SORB_RESULT_W-1:0] ext_q;
  logic [SORB_THR_W-1:0] thr_q;
  logic [15:0] word_q;
  logic low_next_q;
  logic [7:0] rdata_q;
  logic pop_q;
  logic over_q;
  logic restart_q;
  logic standby_q;
  logic int_oe_b_q;
  logic [SORB_RESULT_W-1:0] mag;
  logic [7:0] cur_addr;
  logic soft_hit;
  logic fifo_rd;

  function automatic logic [7:0] sorb_low_byte(input logic [SORB_RESULT_W-1:0] v);
    sorb_low_byte = {v[SORB_HIGH_POS-1:0], 2'h0};
  endfunction

  // address of this byte: start address, or pointer for continued bytes
  always_comb begin
    cur_addr = acc_start_i ? acc_addr_i : ptr_q;
  end

  assign soft_hit = acc_write_i && (acc_start_i || acc_next_i) && cur_addr == SORB_ADDR_SOFT_RESTART
    && acc_wdata_i == SORB_RESTART_CODE;
  assign fifo_rd = !acc_write_i && (acc_start_i || acc_next_i) && cur_addr == SORB_ADDR_FIFO_PORT;

  // address pointer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      ptr_q <= SORB_RESET_VALUE;
    end else if (acc_start_i || acc_next_i) begin
      if (cur_addr == SORB_ADDR_FIFO_PORT && !acc_write_i) begin
        ptr_q <= cur_addr;
      end else if (cur_addr + 8'h01 == SORB_ADDR_FIFO_PORT) begin
        ptr_q <= cur_addr + 8'h02;
      end else begin
        ptr_q <= cur_addr + 8'h01;
      end
    end
  end

  // result capture
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      temp_q <= '0;
      ext_q <= '0;
    end else if (result_valid_i) begin
      temp_q <= temp_value_i;
      ext_q <= ext_input_value_i;
    end
  end

  // threshold registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      thr_q <= '0;
    end else if (acc_write_i && (acc_start_i || acc_next_i)) begin
      if (cur_addr == SORB_ADDR_THR_HIGH) begin
        thr_q[SORB_THR_W-1:SORB_HIGH_POS] <= acc_wdata_i[6:0];
      end else if (cur_addr == SORB_ADDR_THR_LOW) begin
        thr_q[SORB_HIGH_POS-1:0] <= acc_wdata_i[7:SORB_LOW_POS];
      end
    end
  end

  // fifo word staging: pop on first byte, low byte on the next
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      word_q <= '0;
      low_next_q <= 1'b0;
      pop_q <= 1'b0;
    end else begin
      pop_q <= 1'b0;
      if (fifo_rd) begin
        if (!low_next_q) begin
          word_q <= fifo_empty_i ? 16'h0000 : fifo_word_i;
          pop_q <= !fifo_empty_i;
          low_next_q <= 1'b1;
        end else begin
          low_next_q <= 1'b0;
        end
      end
    end
  end

  // read data mux
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      rdata_q <= '0;
    end else if (!acc_write_i && (acc_start_i || acc_next_i)) begin
      unique case (cur_addr)
        SORB_ADDR_TEMP_HIGH: rdata_q <= temp_q[SORB_RESULT_W-1:SORB_HIGH_POS];
        SORB_ADDR_TEMP_LOW: rdata_q <= sorb_low_byte(temp_q);
        SORB_ADDR_EXT_HIGH: rdata_q <= ext_q[SORB_RESULT_W-1:SORB_HIGH_POS];
        SORB_ADDR_EXT_LOW: rdata_q <= sorb_low_byte(ext_q);
        SORB_ADDR_FIFO_PORT: begin
          if (!low_next_q) begin
            rdata_q <= fifo_empty_i ? 8'h00 : fifo_word_i[15:8];
          end else begin
            rdata_q <= word_q[7:0];
          end
        end
        SORB_ADDR_SOFT_RESTART: rdata_q <= 8'h00;
        SORB_ADDR_THR_HIGH: rdata_q <= {1'b0, thr_q[SORB_THR_W-1:SORB_HIGH_POS]};
        SORB_ADDR_THR_LOW: rdata_q <= {thr_q[SORB_HIGH_POS-1:0], 2'h0};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // magnitude of signed sample
  always_comb begin
    mag = sample_i[SORB_RESULT_W-1] ? (~sample_i + 14'h0001) : sample_i;
  end

  // activity compare in raw codes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || soft_hit) begin
      over_q <= 1'b0;
    end else if (sample_valid_i) begin
      over_q <= mag > {1'b0, thr_q};
    end
  end

  // restart pulse, standby and interrupt pin release
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      restart_q <= 1'b0;
      standby_q <= 1'b1;
      int_oe_b_q <= 1'b1;
    end else begin
      restart_q <= soft_hit;
      if (soft_hit) begin
        standby_q <= 1'b1;
        int_oe_b_q <= 1'b1;
      end
    end
  end

  assign rdata_o = rdata_q;
  assign addr_ptr_o = ptr_q;
  assign fifo_pop_o = pop_q;
  assign over_threshold_o = over_q;
  assign soft_restart_o = restart_q;
  assign standby_o = standby_q;
  assign int_oe_b_o = int_oe_b_q;

  // read data
  a_temp_high: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_TEMP_HIGH)
    |=> rdata_o == $past(temp_q[13:6]))
    else $error("temperature high wrong");
  a_temp_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_TEMP_LOW)
    |=> rdata_o == {$past(temp_q[5:0]), 2'h0})
    else $error("temperature low wrong");
  a_ext_high: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_EXT_HIGH)
    |=> rdata_o == $past(ext_q[13:6]))
    else $error("external high wrong");
  a_ext_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_EXT_LOW)
    |=> rdata_o == {$past(ext_q[5:0]), 2'h0})
    else $error("external low wrong");
  a_low_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && (acc_addr_i == SORB_ADDR_TEMP_LOW || acc_addr_i == SORB_ADDR_EXT_LOW))
    |=> rdata_o[1:0] == 2'h0)
    else $error("reserved bits set");
  a_restart_reads0: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_SOFT_RESTART)
    |=> rdata_o == 8'h00)
    else $error("restart register read nonzero");
  a_thr_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_THR_HIGH)
    |=> rdata_o == {1'b0, $past(thr_q[12:6])})
    else $error("threshold high read wrong");

  // threshold and activity
  a_thr_high_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_THR_HIGH)
    |=> thr_q[12:6] == $past(acc_wdata_i[6:0]))
    else $error("threshold high not written");
  a_thr_low_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (acc_write_i && acc_start_i && acc_addr_i == SORB_ADDR_THR_LOW)
    |=> thr_q[5:0] == $past(acc_wdata_i[7:2]))
    else $error("threshold low not written");
  a_over_compare: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (sample_valid_i && !soft_hit)
    |=> over_threshold_o == (($past(sample_i[13]) ? 15'h0000 - {1'b1, $past(sample_i)}
    : {1'b0, $past(sample_i)}) > {2'h0, $past(thr_q)}))
    else $error("activity compare wrong");
  a_over_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!sample_valid_i && !soft_hit)
    |=> $stable(over_threshold_o))
    else $error("activity flag changed without sample");

  // fifo port
  a_fifo_pops: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fifo_rd && !low_next_q && !fifo_empty_i && !soft_hit)
    |=> fifo_pop_o)
    else $error("no pop");
  a_empty_no_pop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fifo_rd && fifo_empty_i)
    |=> !fifo_pop_o)
    else $error("pop from empty fifo");
  a_pop_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fifo_pop_o
    |-> $past(fifo_rd && !low_next_q && !fifo_empty_i))
    else $error("pop without first byte read");
  a_fifo_high: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fifo_rd && !low_next_q && !fifo_empty_i)
    |=> rdata_o == $past(fifo_word_i[15:8]))
    else $error("high byte wrong");
  a_second_byte: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fifo_rd && low_next_q && !soft_hit)
    |=> (rdata_o == $past(word_q[7:0]) && !fifo_pop_o))
    else $error("low byte wrong");
  a_port_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fifo_rd && !soft_hit)
    |=> addr_ptr_o == SORB_ADDR_FIFO_PORT)
    else $error("pointer moved");
  a_skip_port: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (acc_next_i && !acc_start_i && ptr_q == SORB_ADDR_EXT_LOW && !soft_hit)
    |=> (addr_ptr_o == SORB_ADDR_FIFO_PORT + 8'h01 && !fifo_pop_o))
    else $error("port not skipped");

  // pointer
  a_ptr_increment: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (acc_start_i && !soft_hit && acc_addr_i != SORB_ADDR_FIFO_PORT && acc_addr_i + 8'h01 != SORB_ADDR_FIFO_PORT)
    |=> addr_ptr_o == $past(acc_addr_i) + 8'h01)
    else $error("pointer not incremented");
  a_ptr_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!acc_start_i && !acc_next_i)
    |=> $stable(addr_ptr_o))
    else $error("pointer moved while idle");

  // software restart
  a_restart_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_hit
    |=> (restart_q && standby_q && int_oe_b_q && thr_q == '0))
    else $error("restart not applied");
  a_restart_results: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_hit
    |=> (temp_q == '0 && ext_q == '0))
    else $error("results kept over restart");
  a_restart_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !soft_hit
    |=> !soft_restart_o)
    else $error("restart pulse without command");
  a_restart_ptr: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_hit
    |=> (addr_ptr_o == SORB_RESET_VALUE && rdata_o == SORB_RESET_VALUE && !fifo_pop_o && !over_threshold_o))
    else $error("outputs kept over restart");
  a_pin_release: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_hit
    |=> (int_oe_b_o && standby_o))
    else $error("interrupt pins driven after restart");
endmodule
`default_nettype wire

// [tb/sorb_host_model.sv]
// host side model issuing byte accesses to the register bank
`timescale 1ns/1ns
`default_nettype none
module sorb_host_model #(parameter int WAIT_CYC = 100) (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic start_o,
  output logic next_o,
  output logic write_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    start_o = 1'b0;
    next_o = 1'b0;
    write_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one byte; first starts at addr, otherwise continues a multibyte transfer
  task automatic acc(input logic first, input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk_i);
    start_o <= first;
    next_o <= ~first;
    write_o <= wr;
    addr_o <= a;
    wdata_o <= d;
    @(negedge clk_i);
    q = rdata_i;
    start_o <= 1'b0;
    next_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // quiet period after a restart command, shortened
  task automatic settle();
    repeat (WAIT_CYC) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the sensor output register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sorb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic acc_start, acc_next, acc_write, res_valid = 1'b0, samp_valid = 1'b0, fifo_empty = 1'b0;
  logic pop, over_thr, restart, standby, int_oe_b;
  logic [7:0] acc_addr, acc_wdata, rdata, addr_ptr, q;
  logic [13:0] temp_v = '0, ext_v = '0, sample = '0;
  logic [15:0] fifo_word = '0;
  logic [15:0] w[4];
  logic [15:0] fifo_q[$];
  logic [7:0] regs[6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1F, 8'h20};
  int n_fail = 0, comparisons = 0, n_pop = 0, n_restart = 0, thr, s, i;
  always #5 clk_sys_i = ~clk_sys_i;
  sorb_host_model #(.WAIT_CYC(100)) sorb_host_model_inst (.clk_i(clk_sys_i), .rdata_i(rdata),
    .start_o(acc_start), .next_o(acc_next), .write_o(acc_write), .addr_o(acc_addr), .wdata_o(acc_wdata));
  sorb_reg_bank sorb_reg_bank_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .acc_start_i(acc_start),
    .acc_next_i(acc_next), .acc_write_i(acc_write), .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata),
    .temp_value_i(temp_v), .ext_input_value_i(ext_v), .result_valid_i(res_valid),
    .fifo_word_i(fifo_word), .fifo_empty_i(fifo_empty), .fifo_pop_o(pop), .sample_i(sample),
    .sample_valid_i(samp_valid), .rdata_o(rdata), .addr_ptr_o(addr_ptr), .over_threshold_o(over_thr),
    .soft_restart_o(restart), .standby_o(standby), .int_oe_b_o(int_oe_b));
  // fifo source: next head word after each pop
  always @(negedge clk_sys_i) begin
    n_restart = n_restart + int'(restart === 1'b1);
    if (pop === 1'b1 && fifo_q.size() > 0) begin
      n_pop = n_pop + 1;
      void'(fifo_q.pop_front());
      fifo_word <= (fifo_q.size() > 0) ? fifo_q[0] : ~fifo_word;
      fifo_empty <= (fifo_q.size() == 0);
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rdc(input logic first, input logic [7:0] a, input logic [7:0] exp);
    sorb_host_model_inst.acc(first, 1'b0, a, 8'h00, q);
    chk8(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sorb_host_model_inst.acc(1'b1, 1'b1, a, d, q);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #900000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(66759));
    foreach (w[k]) w[k] = 16'($urandom);
    foreach (w[k]) fifo_q.push_back(w[k]);
    fifo_word = w[0];
    repeat (20) @(negedge clk_sys_i);
    rst_b_i <= 1'b1;
    chk1(standby, 1'b1);
    chk1(int_oe_b, 1'b1);
    foreach (regs[k]) rdc(1'b1, regs[k], 8'h00);
    $display("reset values done");
    temp_v <= 14'($urandom);
    ext_v <= 14'($urandom);
    res_valid <= 1'b1;
    @(negedge clk_sys_i);
    res_valid <= 1'b0;
    wr(8'h16, 8'hFF);
    rdc(1'b1, 8'h14, temp_v[13:6]);
    rdc(1'b1, 8'h15, {temp_v[5:0], 2'b00});
    rdc(1'b1, 8'h16, ext_v[13:6]);
    rdc(1'b0, 8'h00, {ext_v[5:0], 2'b00});
    chk8(addr_ptr, 8'h19);
    rdc(1'b0, 8'h00, 8'h00);
    chk8(addr_ptr, 8'h1A);
    @(negedge clk_sys_i);
    chk8(8'(n_pop), 8'h00);
    $display("results and skip done");
    for (i = 0; i < 3; i++) begin
      rdc(i == 0, SORB_ADDR_FIFO_PORT, w[i][15:8]);
      rdc(1'b0, SORB_ADDR_FIFO_PORT, w[i][7:0]);
      chk8(addr_ptr, SORB_ADDR_FIFO_PORT);
    end
    rdc(1'b1, SORB_ADDR_FIFO_PORT, w[3][15:8]);
    rdc(1'b1, SORB_ADDR_FIFO_PORT, w[3][7:0]);
    rdc(1'b0, SORB_ADDR_FIFO_PORT, 8'h00);
    @(negedge clk_sys_i);
    chk8(8'(n_pop), 8'h04);
    $display("fifo port done");
    thr = $urandom_range(8191, 0);
    wr(8'h20, {1'b1, 7'(thr >> 6)});
    wr(8'h21, {6'(thr), 2'b11});
    rdc(1'b1, 8'h20, {1'b0, 7'(thr >> 6)});
    for (i = 0; i < 8; i++) begin
      sample = (i == 0) ? 14'(thr) : (i == 1) ? 14'(-thr - 1) : 14'($urandom);
      s = int'($signed(sample));
      samp_valid = 1'b1;
      @(negedge clk_sys_i);
      samp_valid = 1'b0;
      chk1(over_thr, ((s < 0) ? -s : s) > thr);
    end
    $display("threshold done");
    wr(SORB_ADDR_SOFT_RESTART, 8'h51);
    rdc(1'b1, 8'h20, {1'b0, 7'(thr >> 6)});
    rdc(1'b1, SORB_ADDR_SOFT_RESTART, 8'h00);
    wr(SORB_ADDR_SOFT_RESTART, SORB_RESTART_CODE);
    @(negedge clk_sys_i);
    chk8(8'(n_restart), 8'h01);
    chk1(standby, 1'b1);
    chk1(int_oe_b, 1'b1);
    chk8(addr_ptr, 8'h00);
    chk1(over_thr, 1'b0);
    sorb_host_model_inst.settle();
    rdc(1'b1, 8'h20, 8'h00);
    rdc(1'b1, 8'h14, 8'h00);
    $display("restart done");
    end_of_test();
  end
endmodule
`default_nettype wire
